/* shared/seng_cfg.svh */
/*
  Timing counts and reset values for the serial engine.
  Assumes a 50 MHz core clock; counts derive from printed times.
*/
`ifndef SENG_CFG_SVH
`define SENG_CFG_SVH

`define SENG_CLK_PERIOD_NS 20
`define SENG_TBUF_STD_NS   4700
`define SENG_TBUF_FAST_NS  1300
`define SENG_THD_STA_NS    4000
`define SENG_TSU_STO_NS    4000
// Least times round up to whole cycles
`define SENG_TBUF_STD_CYC  ((`SENG_TBUF_STD_NS + `SENG_CLK_PERIOD_NS - 1) / `SENG_CLK_PERIOD_NS)
`define SENG_TBUF_FAST_CYC ((`SENG_TBUF_FAST_NS + `SENG_CLK_PERIOD_NS - 1) / `SENG_CLK_PERIOD_NS)
`define SENG_THD_STA_CYC   ((`SENG_THD_STA_NS + `SENG_CLK_PERIOD_NS - 1) / `SENG_CLK_PERIOD_NS)
`define SENG_TSU_STO_CYC   ((`SENG_TSU_STO_NS + `SENG_CLK_PERIOD_NS - 1) / `SENG_CLK_PERIOD_NS)
`define SENG_TIMER_W       9
`define SENG_UART_DIV      434
`define SENG_SYNC_STAGES   3
`define SENG_BYTE_BITS     4'h8
`define SENG_RESET_BYTE    8'h00

`endif

/* shared/seng_pkg.sv */
/*
  Types shared by the serial engine modules.
  Assumes seng_cfg.svh for all numeric constants.
*/
package seng_pkg;
  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_AACK, SL_DATA, SL_DACK, SL_HOLD} seng_slave_t;
  typedef enum logic [2:0] {MS_IDLE, MS_WAIT, MS_START, MS_HOLD, MS_STOP} seng_master_t;
  typedef enum logic [2:0] {UR_WAIT_IDLE, UR_IDLE, UR_START, UR_DATA, UR_STOP} seng_uart_t;
endpackage

/* verilog/seng_skid_buf.sv */
/*
  Two-entry receive buffer with valid/ready on both sides.
  Assumes one clock; clr_in empties it synchronously.
*/
`timescale 1ns/1ps
`default_nettype none
module seng_skid_buf #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic         en_in,
  input  wire logic         clr_in,
  input  wire logic         in_valid_in,
  output var  logic         in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output var  logic         out_valid_out,
  input  wire logic         out_ready_in,
  output var  logic [W-1:0] out_data_out
);
  logic [W-1:0] tail;
  logic         tail_v;
  logic         push;
  logic         pop;

  assign push = in_valid_in & ~tail_v;
  assign pop  = out_valid_out & out_ready_in;
  assign in_ready_out = ~tail_v;

  // Head is the visible entry; tail catches a word while head is unread
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
      tail          <= '0;
      tail_v        <= 1'b0;
    end else if (en_in) begin
      if (clr_in) begin
        out_valid_out <= 1'b0;
        tail_v        <= 1'b0;
      end else if (!out_valid_out) begin
        if (push) begin
          out_data_out  <= in_data_in;
          out_valid_out <= 1'b1;
        end
      end else if (pop) begin
        if (tail_v) begin
          out_data_out <= tail;
          tail_v       <= 1'b0;
        end else if (push) begin
          out_data_out <= in_data_in;
        end else begin
          out_valid_out <= 1'b0;
        end
      end else if (push) begin
        tail   <= in_data_in;
        tail_v <= 1'b1;
      end
    end
  end
endmodule // seng_skid_buf
`default_nettype wire

/* verilog/seng_uart_rx.sv */
/*
  UART 8N1 receiver with busy and framing-error reporting.
  Assumes rx_in is already synchronised to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seng_cfg.svh"
module seng_uart_rx
  import seng_pkg::*;
#(
  parameter int DIV = `SENG_UART_DIV
) (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       en_in,
  input  wire logic       clr_in,
  input  wire logic       rx_in,
  output var  logic [7:0] data_out,
  output var  logic       valid_out,
  output var  logic       busy_out,
  output var  logic       frame_err_out
);
  seng_uart_t  state;
  logic [15:0] tick;
  logic [3:0]  nbit;
  logic [7:0]  shreg;
  logic        tick_end;

  assign tick_end = (tick == 16'(DIV - 1));

  // Clearing forces a fresh idle-line wait, so a byte cut short by reset
  // leaves no half frame behind to be misread as a framing error
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state         <= UR_WAIT_IDLE;
      tick          <= 16'h0000;
      nbit          <= 4'h0;
      shreg         <= `SENG_RESET_BYTE;
      data_out      <= `SENG_RESET_BYTE;
      valid_out     <= 1'b0;
      busy_out      <= 1'b0;
      frame_err_out <= 1'b0;
    end else if (en_in) begin
      valid_out <= 1'b0;
      tick      <= tick_end ? 16'h0000 : tick + 16'h0001;
      if (clr_in) begin
        state         <= UR_WAIT_IDLE;
        busy_out      <= 1'b0;
        frame_err_out <= 1'b0;
      end else begin
        case (state)
          UR_WAIT_IDLE: if (rx_in) state <= UR_IDLE;
          UR_IDLE: if (!rx_in) begin
            state    <= UR_START;
            tick     <= 16'(DIV / 2);  // Sample mid-bit
            busy_out <= 1'b1;
          end
          UR_START: if (tick_end) begin
            state <= rx_in ? UR_IDLE : UR_DATA; // Glitch rejects
            busy_out <= ~rx_in;
            nbit  <= 4'h0;
          end
          UR_DATA: if (tick_end) begin
            shreg <= {rx_in, shreg[7:1]};
            nbit  <= nbit + 4'h1;
            if (nbit == `SENG_BYTE_BITS - 4'h1) state <= UR_STOP;
          end
          UR_STOP: if (tick_end) begin
            data_out      <= shreg;
            valid_out     <= 1'b1;
            frame_err_out <= ~rx_in;
            busy_out      <= 1'b0;
            state         <= rx_in ? UR_IDLE : UR_WAIT_IDLE;
          end
          default: state <= UR_WAIT_IDLE;
        endcase
      end
    end
  end
endmodule // seng_uart_rx
`default_nettype wire

/* verilog/seng_core.sv */
/*
  Serial engine: I2C slave receiver with two-entry receive buffer,
  I2C master start/stop generator with bus-free wait, UART receiver.
  Assumes open-drain SCL/SDA resolved outside; pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seng_cfg.svh"
module seng_core
  import seng_pkg::*;
#(
  parameter int UART_DIV = `SENG_UART_DIV
) (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       en_in,
  input  wire logic       scl_in,
  output var  logic       scl_out,
  output var  logic       scl_oe_out,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe_out,
  input  wire logic       uart_rx_in,
  input  wire logic [6:0] own_addr_in,
  input  wire logic       fast_mode_in,
  input  wire logic       soft_reset_bit_in,
  input  wire logic       sync_mode_bit_in,
  input  wire logic       abort_rx_in,
  input  wire logic       start_req_in,
  input  wire logic       stop_req_in,
  input  wire logic       i2c_rx_read_in,
  output var  logic [7:0] i2c_rx_buffer_out,
  output var  logic       i2c_rx_flag_out,
  output var  logic       scl_low_status_out,
  output var  logic       bus_busy_flag_out,
  output var  logic       start_request_bit_out,
  output var  logic [7:0] uart_data_out,
  output var  logic       uart_valid_out,
  output var  logic       uart_busy_flag_out,
  output var  logic       uart_frame_err_out
);
  localparam int NSYNC = 3;
  localparam logic [`SENG_TIMER_W-1:0] TBUF_STD  = `SENG_TIMER_W'(`SENG_TBUF_STD_CYC);
  localparam logic [`SENG_TIMER_W-1:0] TBUF_FAST = `SENG_TIMER_W'(`SENG_TBUF_FAST_CYC);
  localparam logic [`SENG_TIMER_W-1:0] THD_STA   = `SENG_TIMER_W'(`SENG_THD_STA_CYC);
  localparam logic [`SENG_TIMER_W-1:0] TSU_STO   = `SENG_TIMER_W'(`SENG_TSU_STO_CYC);

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_lvl;
  logic             scl_s;
  logic             sda_s;
  logic             urx_s;
  logic             scl_q;
  logic             sda_q;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;
  logic             mod_clr;

  seng_slave_t      sl_state;
  logic [3:0]       sl_cnt;
  logic [7:0]       sl_shreg;
  logic             sl_sda;
  logic             sl_scl;
  logic             buf_push;
  logic             buf_ready;

  seng_master_t     ms_state;
  logic [`SENG_TIMER_W-1:0] ms_tmr;
  logic             ms_sda;
  logic             ms_scl;
  logic [`SENG_TIMER_W-1:0] tbuf_cyc;

  assign pin_raw  = {uart_rx_in, sda_in, scl_in};
  assign scl_s    = pin_lvl[0];
  assign sda_s    = pin_lvl[1];
  assign urx_s    = pin_lvl[2];
  assign mod_clr  = soft_reset_bit_in;
  assign tbuf_cyc = fast_mode_in ? TBUF_FAST : TBUF_STD;

  // Three-stage synchronisers; the level moves only when stages two and
  // three agree, so a metastable first stage is never looked at
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic [2:0] ff;
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          ff         <= 3'h7;
          pin_lvl[gi] <= 1'b1;
        end else if (en_in) begin
          ff <= {ff[1:0], pin_raw[gi]};
          if (ff[1] == ff[2]) pin_lvl[gi] <= ff[2];
        end
      end
    end
  endgenerate

  // Previous line levels for edge and condition detection
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (en_in) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

  // Bus busy from START to STOP, whoever drives them
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_busy_flag_out <= 1'b0;
    end else if (en_in) begin
      if (mod_clr || stop_det) bus_busy_flag_out <= 1'b0;
      else if (start_det) bus_busy_flag_out <= 1'b1;
    end
  end

  // Slave receiver. A full buffer stretches SCL in the ACK slot instead
  // of racing software, so a late read can never cost a byte
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sl_state <= SL_IDLE;
      sl_cnt   <= 4'h0;
      sl_shreg <= `SENG_RESET_BYTE;
      sl_sda   <= 1'b0;
      sl_scl   <= 1'b0;
      buf_push <= 1'b0;
    end else if (en_in) begin
      buf_push <= 1'b0;
      if (mod_clr || ms_state != MS_IDLE) begin
        sl_state <= SL_IDLE;
        sl_sda   <= 1'b0;
        sl_scl   <= 1'b0;
      end else if (start_det) begin
        sl_state <= SL_ADDR;
        sl_cnt   <= 4'h0;
        sl_sda   <= 1'b0;
      end else if (stop_det) begin
        sl_state <= SL_IDLE;
        sl_sda   <= 1'b0;
        sl_scl   <= 1'b0;
      end else begin
        case (sl_state)
          SL_IDLE: sl_sda <= 1'b0;
          SL_ADDR, SL_DATA: begin
            if (scl_rise && sl_cnt != `SENG_BYTE_BITS) begin
              sl_shreg <= {sl_shreg[6:0], sda_s};
              sl_cnt   <= sl_cnt + 4'h1;
            end else if (scl_fall && sl_cnt == `SENG_BYTE_BITS) begin
              if (sl_state == SL_ADDR) begin
                if (sl_shreg[7:1] == own_addr_in && !sl_shreg[0]) begin
                  sl_sda   <= 1'b1;
                  sl_state <= SL_AACK;
                end else begin
                  sl_state <= SL_IDLE;
                end
              end else if (abort_rx_in) begin
                sl_state <= SL_IDLE;    // SDA left released: NACK
              end else if (buf_ready) begin
                buf_push <= 1'b1;
                sl_sda   <= 1'b1;
                sl_state <= SL_DACK;
              end else begin
                sl_scl   <= 1'b1;
                sl_state <= SL_HOLD;
              end
            end
          end
          SL_HOLD: if (abort_rx_in) begin
            sl_scl   <= 1'b0;
            sl_state <= SL_IDLE;
          end else if (buf_ready) begin
            buf_push <= 1'b1;
            sl_sda   <= 1'b1;
            sl_scl   <= 1'b0;
            sl_state <= SL_DACK;
          end
          SL_AACK, SL_DACK: if (scl_fall) begin
            sl_sda   <= 1'b0;
            sl_cnt   <= 4'h0;
            sl_state <= SL_DATA;
          end
          default: sl_state <= SL_IDLE;
        endcase
      end
    end
  end

  // Receive buffer: a read pops one entry; flag mirrors head valid
  seng_skid_buf #(
    .W (8)
  ) u_rx_buf (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .en_in         (en_in),
    .clr_in        (mod_clr),
    .in_valid_in   (buf_push),
    .in_ready_out  (buf_ready),
    .in_data_in    (sl_shreg),
    .out_valid_out (i2c_rx_flag_out),
    .out_ready_in  (i2c_rx_read_in),
    .out_data_out  (i2c_rx_buffer_out)
  );

  // Master start/stop. The bus-free timer restarts on any activity, so a
  // start queued during a foreign transfer goes out only after release
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ms_state <= MS_IDLE;
      ms_tmr   <= '0;
      ms_sda   <= 1'b0;
      ms_scl   <= 1'b0;
    end else if (en_in) begin
      if (mod_clr) begin
        ms_state <= MS_IDLE;
        ms_sda   <= 1'b0;
        ms_scl   <= 1'b0;
      end else begin
        case (ms_state)
          MS_IDLE: if (start_request_bit_out) begin
            ms_state <= MS_WAIT;
            ms_tmr   <= '0;
          end
          MS_WAIT: begin
            if (bus_busy_flag_out || !scl_s || !sda_s) begin
              ms_tmr <= '0;
            end else if (ms_tmr >= tbuf_cyc - 1'b1) begin
              ms_sda   <= 1'b1;
              ms_tmr   <= '0;
              ms_state <= MS_START;
            end else begin
              ms_tmr <= ms_tmr + 1'b1;
            end
          end
          MS_START: if (ms_tmr >= THD_STA - 1'b1) begin
            ms_scl   <= 1'b1;
            ms_state <= MS_HOLD;
          end else begin
            ms_tmr <= ms_tmr + 1'b1;
          end
          MS_HOLD: if (stop_req_in) begin
            ms_scl   <= 1'b0;
            ms_tmr   <= '0;
            ms_state <= MS_STOP;
          end
          MS_STOP: if (!scl_s) begin
            ms_tmr <= '0;               // Wait out clock stretching
          end else if (ms_tmr >= TSU_STO - 1'b1) begin
            ms_sda   <= 1'b0;
            ms_state <= MS_IDLE;
          end else begin
            ms_tmr <= ms_tmr + 1'b1;
          end
          default: ms_state <= MS_IDLE;
        endcase
      end
    end
  end

  // Start request holds until the start is driven; a new request in the
  // cycle the start completes wins so it is not dropped; soft reset still clears it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      start_request_bit_out <= 1'b0;
    end else if (en_in) begin
      if (start_req_in && !mod_clr) start_request_bit_out <= 1'b1;
      else if (mod_clr || (ms_state == MS_START && ms_scl == 1'b0 && ms_tmr >= THD_STA - 1'b1))
        start_request_bit_out <= 1'b0;
    end
  end

  // Open-drain pins: data always 0, enables registered
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_out            <= 1'b0;
      sda_out            <= 1'b0;
      scl_oe_out         <= 1'b0;
      sda_oe_out         <= 1'b0;
      scl_low_status_out <= 1'b0;
    end else if (en_in) begin
      scl_oe_out         <= sl_scl | ms_scl;
      sda_oe_out         <= sl_sda | ms_sda;
      scl_low_status_out <= ~scl_s;
    end
  end

  // UART receiver; soft reset or sync mode clears its frame state
  seng_uart_rx #(
    .DIV (UART_DIV)
  ) u_uart_rx (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .en_in         (en_in),
    .clr_in        (mod_clr | sync_mode_bit_in),
    .rx_in         (urx_s),
    .data_out      (uart_data_out),
    .valid_out     (uart_valid_out),
    .busy_out      (uart_busy_flag_out),
    .frame_err_out (uart_frame_err_out)
  );
endmodule // seng_core
`default_nettype wire

/* test/seng_core_properties.sv */
/*
  Concurrent checks on the serial engine's ports.
  Assumes it is bound onto seng_core and sees one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seng_cfg.svh"
module seng_core_checker (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_oe_out,
  input wire logic sda_oe_out,
  input wire logic uart_rx_in,
  input wire logic fast_mode_in,
  input wire logic soft_reset_bit_in,
  input wire logic sync_mode_bit_in,
  input wire logic abort_rx_in,
  input wire logic i2c_rx_read_in,
  input wire logic i2c_rx_flag_out,
  input wire logic scl_low_status_out,
  input wire logic bus_busy_flag_out,
  input wire logic start_request_bit_out,
  input wire logic uart_valid_out,
  input wire logic uart_busy_flag_out,
  input wire logic uart_frame_err_out
);
  localparam int TB_STD  = `SENG_TBUF_STD_CYC;
  localparam int TB_FAST = `SENG_TBUF_FAST_CYC;
  logic [8:0] idle_cnt;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Raw lines rise before the synced ones, so this count is never shorter than the engine's
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idle_cnt <= 9'h000;
    end else if (bus_busy_flag_out || !scl_in || !sda_in) begin
      idle_cnt <= 9'h000;
    end else if (idle_cnt != 9'h1FF) begin
      idle_cnt <= idle_cnt + 9'h001;
    end
  end

  a_start_bus_free: assert property ($rose(sda_oe_out) && scl_in && !bus_busy_flag_out
    |-> int'(idle_cnt) >= (fast_mode_in ? TB_FAST : TB_STD) - 1) else $error("start before bus-free time");
  // The request drops on the edge that starts pulling SCL; the pin enable follows one cycle later
  a_start_bit_clear: assert property ($fell(start_request_bit_out)
    |=> (scl_oe_out && sda_oe_out) || $past(soft_reset_bit_in) || $past(soft_reset_bit_in, 2))
    else $error("request cleared early");
  a_flag_fall_read: assert property ($fell(i2c_rx_flag_out)
    |-> $past(i2c_rx_read_in) || $past(soft_reset_bit_in)) else $error("receive flag fell without a read");
  a_flag_rise_ack: assert property ($rose(i2c_rx_flag_out) && !abort_rx_in |-> sda_oe_out)
    else $error("buffered byte not acknowledged");
  a_scl_low_set: assert property ((!scl_in)[*6] |-> scl_low_status_out)
    else $error("clock-low status missing");
  a_scl_low_clr: assert property (scl_in[*6] |-> !scl_low_status_out)
    else $error("clock-low status stuck");
  a_uart_busy_edge: assert property ($rose(uart_busy_flag_out)
    |-> !($past(uart_rx_in, 2) && $past(uart_rx_in, 3) && $past(uart_rx_in, 4) && $past(uart_rx_in, 5)))
    else $error("uart busy without start edge");
  a_uart_valid_end: assert property (uart_valid_out |-> $past(uart_busy_flag_out) && !uart_busy_flag_out)
    else $error("uart busy wrong around byte end");
  a_soft_reset_hold: assert property (soft_reset_bit_in && $past(soft_reset_bit_in)
    |-> !(i2c_rx_flag_out || uart_busy_flag_out || bus_busy_flag_out || start_request_bit_out || scl_oe_out))
    else $error("state survives soft reset");
  a_sync_clear_err: assert property (sync_mode_bit_in && $past(sync_mode_bit_in) |-> !uart_frame_err_out)
    else $error("framing error survives sync toggle");
endmodule // seng_core_checker
`default_nettype wire

/* test/seng_link_model.sv */
/*
  Far side of the engine: a bit-banging I2C master and a UART sender.
  Assumes pull-ups on both bus lines; the wire level is resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
module seng_link_model (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output var  logic scl_pull_out,
  output var  logic sda_pull_out,
  output var  logic uart_tx_out
);
  logic [3:0] acks;

  // Released lines float high through their pull-ups
  initial begin
    scl_pull_out = 1'b0;
    sda_pull_out = 1'b0;
    uart_tx_out  = 1'b1;
    acks         = 4'h0;
  end

  // One bit slot; data changes only while SCL is low, and a stretch is honoured
  task automatic slot(input logic b, input int lo, output logic s);
    int k;
    #(lo / 2) sda_pull_out = !b;
    #(lo / 2) scl_pull_out = 1'b0;
    for (k = 0; k < 4000 && scl_in !== 1'b1; k++) #20;
    #80 s = sda_in;
    scl_pull_out = 1'b1;
  endtask

  task automatic bus_start();
    sda_pull_out = 1'b1;
    #80 scl_pull_out = 1'b1;
  endtask

  task automatic bus_stop();
    #40 sda_pull_out = 1'b1;
    #120 scl_pull_out = 1'b0;
    #160 sda_pull_out = 1'b0;
    #160;
  endtask

  // Address then n bytes MSB first; long low phases before the ACK slot give a slow slave room
  task automatic frame(input logic [7:0] a, input logic [23:0] d, input int n, input logic stop);
    logic [31:0] w;
    logic        s;
    w = {a, d};
    bus_start();
    for (int j = 0; j <= n; j++) begin
      for (int i = 0; i < 8; i++) slot(w[31 - 8 * j - i], (i == 0) ? 320 : 80, s);
      slot(1'b1, 320, s);
      acks[j] = s;
    end
    if (stop) bus_stop();
  endtask

  // 8N1, LSB first, 160 ns a bit
  task automatic uart_send(input logic [7:0] d, input logic stop_bit);
    uart_tx_out = 1'b0;
    for (int i = 0; i < 8; i++) #160 uart_tx_out = d[i];
    #160 uart_tx_out = stop_bit;
    #160 uart_tx_out = 1'b1;
    #320;
  endtask
endmodule // seng_link_model
`default_nettype wire

/* test/serial_i2c_uart_engine_bench.sv */
/*
  Self-checking bench for seng_core: I2C reception, start generation, UART.
  Assumes the link model and the bound checker; uart divider shortened to 8.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seng_cfg.svh"
module serial_i2c_uart_engine_bench;
  logic       clk_in, rst_b_in, abort, sreset, sync, fast, sreq_p, stop_p, rd;
  logic       scl_oe, sda_oe, m_scl, m_sda, utx, scl_w, sda_w, scl_o, sda_o;
  logic       flag, scl_low, bbusy, sreq, uvalid, ubusy, ferr;
  logic [7:0] rxb, udata, u_got;
  int         n_mismatch, total_checks, cyc, u_cnt, k, tb;

  assign scl_w = !(m_scl || scl_oe);
  assign sda_w = !(m_sda || sda_oe);

  seng_core #(.UART_DIV(8)) dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .en_in(1'b1), .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe), .uart_rx_in(utx), .own_addr_in(7'h2A),
    .fast_mode_in(fast), .soft_reset_bit_in(sreset), .sync_mode_bit_in(sync), .abort_rx_in(abort),
    .start_req_in(sreq_p), .stop_req_in(stop_p), .i2c_rx_read_in(rd), .i2c_rx_buffer_out(rxb),
    .i2c_rx_flag_out(flag), .scl_low_status_out(scl_low), .bus_busy_flag_out(bbusy),
    .start_request_bit_out(sreq), .uart_data_out(udata), .uart_valid_out(uvalid),
    .uart_busy_flag_out(ubusy), .uart_frame_err_out(ferr));

  seng_link_model m (.scl_in(scl_w), .sda_in(sda_w), .scl_pull_out(m_scl), .sda_pull_out(m_sda), .uart_tx_out(utx));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Valid is a one-cycle pulse, so catch it here
  always @(posedge clk_in) begin
    cyc++;
    if (uvalid === 1'b1) begin
      u_got <= udata;
      u_cnt <= u_cnt + 1;
    end
    if (cyc == 40000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk_in);
    #2;
  endtask

  // Read strobe is sampled at one edge; the head updates at that same edge
  task automatic pop();
    rd = 1'b1;
    tick();
    rd = 1'b0;
    tick();
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {rst_b_in, abort, sreset, sync, fast, sreq_p, stop_p, rd} = 8'h00;
    repeat (12) @(posedge clk_in);
    #2 rst_b_in = 1'b1;
    repeat (4) tick();
    check(flag, 1'b0);
    // Three bytes unread: the third must be stretched, not lost
    fork
      m.frame(8'h54, 24'hA53C0F, 3, 1'b1);
      begin
        for (k = 0; k < 3000 && scl_oe !== 1'b1; k++) tick();
        repeat (24) tick();
        check(scl_low, 1'b1);
        check(flag, 1'b1);
        check(rxb, 8'hA5);
        pop();
        check(rxb, 8'h3C);
        pop();
        for (k = 0; k < 3000 && flag !== 1'b1; k++) tick();
        check(rxb, 8'h0F);
        pop();
        check(flag, 1'b0);
      end
    join
    check(m.acks, 4'h0);
    m.frame(8'h56, 24'h110000, 1, 1'b1);
    check(m.acks[1:0], 2'b11);
    abort = 1'b1;
    m.frame(8'h54, 24'h770000, 1, 1'b1);
    abort = 1'b0;
    check(m.acks[1:0], 2'b10);
    check(flag, 1'b0);
    // Start requested during a foreign transaction, in both speed modes
    for (int f = 0; f < 2; f++) begin
      fast = f[0];
      tb = f ? `SENG_TBUF_FAST_CYC : `SENG_TBUF_STD_CYC;
      m.bus_start();
      repeat (6) tick();
      check(bbusy, 1'b1);
      sreq_p = 1'b1;
      tick();
      sreq_p = 1'b0;
      tick();
      check(sreq, 1'b1);
      repeat (300) tick();
      check(sda_oe, 1'b0);
      m.bus_stop();
      for (k = 0; k < 2000 && sda_oe !== 1'b1; k++) tick();
      check(8'(k + 8 >= tb && k <= tb + 12), 1'b1);
      check(sreq, 1'b1);
      for (k = 0; k < 400 && sreq !== 1'b0; k++) tick();
      // SCL enable is registered one cycle behind the request clearing
      tick();
      check({scl_oe, sda_oe}, 2'b11);
      check({scl_o, sda_o}, 2'b00);
      stop_p = 1'b1;
      tick();
      stop_p = 1'b0;
      for (k = 0; k < 1000 && sda_oe !== 1'b0; k++) tick();
      repeat (8) tick();
      check({scl_oe, bbusy}, 2'b00);
    end
    fork
      m.uart_send(8'hA5, 1'b1);
      begin
        repeat (40) tick();
        check(ubusy, 1'b1);
      end
    join
    check(u_got, 8'hA5);
    check(u_cnt[7:0], 8'h01);
    m.uart_send(8'h5A, 1'b0);
    check(ferr, 1'b1);
    // Soft reset in mid-byte, with the sync-mode toggle, then a clean byte
    fork
      m.uart_send(8'hC3, 1'b1);
      begin
        repeat (30) tick();
        sreset = 1'b1;
        repeat (3) tick();
        check({ubusy, ferr}, 2'b00);
        sync = 1'b1;
        repeat (2) tick();
        sync = 1'b0;
      end
    join
    sreset = 1'b0;
    tick();
    m.uart_send(8'h3C, 1'b1);
    check(u_got, 8'h3C);
    check(ferr, 1'b0);
    conclude();
  end
endmodule // serial_i2c_uart_engine_bench

bind seng_core seng_core_checker chk (.clk_in, .rst_b_in, .scl_in, .sda_in, .scl_oe_out, .sda_oe_out, .uart_rx_in,
  .fast_mode_in, .soft_reset_bit_in, .sync_mode_bit_in, .abort_rx_in, .i2c_rx_read_in, .i2c_rx_flag_out,
  .scl_low_status_out, .bus_busy_flag_out, .start_request_bit_out, .uart_valid_out, .uart_busy_flag_out,
  .uart_frame_err_out);
`default_nettype wire
